// file: core/lbt_tracker.sv
/*
  Four-bank state tracker and command legality checker for a low-power DDR
  memory. Commands are sampled on clk_sys; the command pins come from
  outside and are synchronised first. Power-down, self refresh and
  initialization are outside this block: tracking_en tells it when the
  clock enable and exit times allow normal operation.
*/
`default_nettype none
// Function
// - Track only when clock enable high twice
// - Idle only after precharge plus tRP
// - Row active after tRCD, no burst
// - Read/write state until burst ends
// - Precharge lasts tRP then idle
// - Activate lasts tRCD then row active
// - Auto precharge lasts until tRP done
// - Refresh lasts tRFC, banks idle
// - Mode load lasts tMRD, banks idle
// - Precharge all lasts tRP, banks idle
// - Burst terminate ends latest read
// - Decode command from four strobes
// - Each bank judged by its state
// - Concurrent auto precharge other banks
// - Auto precharge start after burst/tWR
// - A10 selects auto precharge
// - A10 selects all-bank precharge
module lbt_tracker #(
  parameter int BL = lbt_pkg::BL_DEF,
  parameter int CL = lbt_pkg::CL_DEF,
  parameter int RP = lbt_pkg::RP_CYC,
  parameter int RCD = lbt_pkg::RCD_CYC,
  parameter int RFC = lbt_pkg::RFC_CYC,
  parameter int MRD = lbt_pkg::T_MRD_CK,
  parameter int WR = lbt_pkg::WR_CYC,
  parameter int WTR = lbt_pkg::T_WTR_CK
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic cke,
  input wire logic tracking_en,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [lbt_pkg::BA_W-1:0] ba,
  input wire logic [lbt_pkg::ADDR_W-1:0] addr,
  output logic [lbt_pkg::NBANK*8-1:0] bank_state,
  output logic [3:0] dev_state,
  output logic cmd_valid,
  output logic cmd_illegal,
  output logic burst_active,
  output logic all_idle
);
  localparam logic [lbt_pkg::CNT_W-1:0] BLH = lbt_pkg::CNT_W'(BL / 2);
  localparam logic [lbt_pkg::CNT_W-1:0] RP_C = lbt_pkg::CNT_W'(RP);
  localparam logic [lbt_pkg::CNT_W-1:0] RFC_C = lbt_pkg::CNT_W'(RFC);
  localparam logic [lbt_pkg::CNT_W-1:0] MRD_C = lbt_pkg::CNT_W'(MRD);
  // A spacing counter loaded with N refuses the next N edges, so a minimum
  // distance of D clocks loads D - 1: the command D clocks later is legal.
  localparam logic [lbt_pkg::CNT_W-1:0] RDGAP = lbt_pkg::CNT_W'(BL / 2 - 1);
  localparam logic [lbt_pkg::CNT_W-1:0] RD2WR =
    lbt_pkg::CNT_W'(CL + BL / 2 - 1);
  localparam logic [lbt_pkg::CNT_W-1:0] WR2RD =
    lbt_pkg::CNT_W'(BL / 2 + WTR);
  localparam logic [lbt_pkg::CNT_W-1:0] WRGAP = lbt_pkg::CNT_W'(BL / 2 - 1);
  localparam logic [lbt_pkg::CNT_W-1:0] WR_AP =
    lbt_pkg::CNT_W'(1 + BL / 2 + WR);

  // Two-stage synchronisers on the cke, tracking_en, command, bank and A10 inputs; other addr bits are not used.
  localparam int PIN_W = 6 + lbt_pkg::BA_W + 1;
  logic [PIN_W-1:0] pin_s1_r, pin_s2_r;
  logic cke_prev_r;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_s1_r <= {PIN_W{1'b1}};
      pin_s2_r <= {PIN_W{1'b1}};
      cke_prev_r <= 1'b0;
    end else begin
      pin_s1_r <= {cke, tracking_en, cs_n, ras_n, cas_n, we_n, ba,
                   addr[lbt_pkg::ADDR_AP_BIT]};
      pin_s2_r <= pin_s1_r;
      cke_prev_r <= pin_s2_r[PIN_W-1];
    end
  end

  lbt_pkg::lbt_dcmd_t dc;
  lbt_decode u_dec (
    .cs_n(pin_s2_r[PIN_W-3]),
    .ras_n(pin_s2_r[PIN_W-4]),
    .cas_n(pin_s2_r[PIN_W-5]),
    .we_n(pin_s2_r[PIN_W-6]),
    .ba(pin_s2_r[lbt_pkg::BA_W:1]),
    .a10(pin_s2_r[0]),
    .dcmd(dc)
  );

  // Commands count only with the clock enable high on both edges.
  wire logic live = cke_prev_r && pin_s2_r[PIN_W-1] && pin_s2_r[PIN_W-2];

  lbt_pkg::lbt_bank_st_t bst [lbt_pkg::NBANK];
  lbt_pkg::lbt_dev_st_t dev_r, dev_nxt;
  logic [lbt_pkg::CNT_W-1:0] dcnt_r, dcnt_nxt;
  logic [lbt_pkg::CNT_W-1:0] burst_r, burst_nxt;
  logic [lbt_pkg::CNT_W-1:0] gap_rd_r, gap_rd_nxt, gap_wr_r, gap_wr_nxt;
  logic [lbt_pkg::BA_W-1:0] rd_bank_r, rd_bank_nxt;
  logic burst_is_rd_r, burst_is_rd_nxt;
  logic [lbt_pkg::NBANK-1:0] idle_v, busy_v, open_v, pre_ok_v, end_v;
  logic ok, force_idle;
  logic [lbt_pkg::NBANK-1:0] go_act, go_rd, go_wr, go_pre;

  always_comb begin
    for (int i = 0; i < lbt_pkg::NBANK; i++) begin
      idle_v[i] = bst[i] == lbt_pkg::LBT_B_IDLE;
      busy_v[i] = bst[i] == lbt_pkg::LBT_B_ACTG ||
                  bst[i] == lbt_pkg::LBT_B_PREG ||
                  bst[i] == lbt_pkg::LBT_B_RDAP ||
                  bst[i] == lbt_pkg::LBT_B_WRAP;
      open_v[i] = bst[i] == lbt_pkg::LBT_B_ACTV ||
                  bst[i] == lbt_pkg::LBT_B_RD || bst[i] == lbt_pkg::LBT_B_WR;
      pre_ok_v[i] = open_v[i] || idle_v[i];
    end
  end

  // Legality: each bank is judged by its own state plus the shared burst and spacing counters.
  always_comb begin
    ok = 1'b1;
    case (dc.cmd)
      lbt_pkg::LBT_CMD_DESEL, lbt_pkg::LBT_CMD_NOP: ok = 1'b1;
      lbt_pkg::LBT_CMD_ACT: ok = idle_v[dc.bank];
      lbt_pkg::LBT_CMD_RD:
        ok = open_v[dc.bank] && gap_rd_r == '0;
      lbt_pkg::LBT_CMD_WR:
        ok = open_v[dc.bank] && gap_wr_r == '0 &&
             !(burst_r != '0 && burst_is_rd_r);
      lbt_pkg::LBT_CMD_PRE:
        ok = dc.ap ? (&pre_ok_v) : pre_ok_v[dc.bank];
      lbt_pkg::LBT_CMD_REF, lbt_pkg::LBT_CMD_LMR:
        ok = (&idle_v) && burst_r == '0;
      lbt_pkg::LBT_CMD_BST: ok = 1'b1;
      default: ok = 1'b0;
    endcase
    if (dev_r != lbt_pkg::LBT_D_NORM && dc.cmd != lbt_pkg::LBT_CMD_DESEL &&
        dc.cmd != lbt_pkg::LBT_CMD_NOP) begin
      ok = 1'b0;
    end
  end

  wire logic take = live && ok;

  // Device-wide state, burst tracking and concurrent spacing counters.
  always_comb begin
    dev_nxt = dev_r;
    dcnt_nxt = (dcnt_r != '0) ? dcnt_r - 1'b1 : dcnt_r;
    burst_nxt = (burst_r != '0) ? burst_r - 1'b1 : burst_r;
    gap_rd_nxt = (gap_rd_r != '0) ? gap_rd_r - 1'b1 : gap_rd_r;
    gap_wr_nxt = (gap_wr_r != '0) ? gap_wr_r - 1'b1 : gap_wr_r;
    rd_bank_nxt = rd_bank_r;
    burst_is_rd_nxt = burst_is_rd_r;
    force_idle = 1'b0;
    end_v = '0;
    go_act = '0;
    go_rd = '0;
    go_wr = '0;
    go_pre = '0;
    if (burst_r == 1) begin
      end_v = '1;
    end
    case (dev_r)
      lbt_pkg::LBT_D_NORM: if (take) begin
        case (dc.cmd)
          lbt_pkg::LBT_CMD_ACT: go_act[dc.bank] = 1'b1;
          lbt_pkg::LBT_CMD_RD: begin
            go_rd[dc.bank] = 1'b1;
            burst_nxt = BLH;
            burst_is_rd_nxt = 1'b1;
            rd_bank_nxt = dc.bank;
            if (dc.ap) begin
              gap_rd_nxt = RDGAP;
              gap_wr_nxt = RD2WR;
            end
          end
          lbt_pkg::LBT_CMD_WR: begin
            go_wr[dc.bank] = 1'b1;
            burst_nxt = BLH;
            burst_is_rd_nxt = 1'b0;
            if (dc.ap) begin
              gap_rd_nxt = WR2RD;
              gap_wr_nxt = WRGAP;
            end
          end
          lbt_pkg::LBT_CMD_PRE: begin
            if (dc.ap) begin
              dev_nxt = lbt_pkg::LBT_D_PALL;
              dcnt_nxt = RP_C;
              burst_nxt = '0;
            end else begin
              go_pre[dc.bank] = 1'b1;
              if (burst_r != '0 && dc.bank == rd_bank_r) begin
                burst_nxt = '0;
              end
            end
          end
          lbt_pkg::LBT_CMD_REF: begin
            dev_nxt = lbt_pkg::LBT_D_REF;
            dcnt_nxt = RFC_C;
          end
          lbt_pkg::LBT_CMD_LMR: begin
            dev_nxt = lbt_pkg::LBT_D_MRS;
            dcnt_nxt = MRD_C;
          end
          lbt_pkg::LBT_CMD_BST: if (burst_r != '0 && burst_is_rd_r) begin
            end_v[rd_bank_r] = 1'b1;
            burst_nxt = '0;
          end
          default: ;
        endcase
      end
      lbt_pkg::LBT_D_REF, lbt_pkg::LBT_D_MRS, lbt_pkg::LBT_D_PALL: begin
        force_idle = 1'b1;
        if (dcnt_r <= 1) begin
          dev_nxt = lbt_pkg::LBT_D_NORM;
        end
      end
      default: dev_nxt = lbt_pkg::LBT_D_NORM;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dev_r <= lbt_pkg::LBT_D_NORM;
      dcnt_r <= '0;
      burst_r <= '0;
      gap_rd_r <= '0;
      gap_wr_r <= '0;
      rd_bank_r <= '0;
      burst_is_rd_r <= 1'b0;
    end else begin
      dev_r <= dev_nxt;
      dcnt_r <= dcnt_nxt;
      burst_r <= burst_nxt;
      gap_rd_r <= gap_rd_nxt;
      gap_wr_r <= gap_wr_nxt;
      rd_bank_r <= rd_bank_nxt;
      burst_is_rd_r <= burst_is_rd_nxt;
    end
  end

  // Auto precharge waits for the burst (read) or burst plus write recovery.
  wire logic [lbt_pkg::CNT_W-1:0] ap_delay =
    (dc.cmd == lbt_pkg::LBT_CMD_RD) ? BLH : WR_AP;

  for (genvar b = 0; b < lbt_pkg::NBANK; b++) begin : g_bank
    lbt_bank #(
      .RP(RP),
      .RCD(RCD)
    ) u_bank (
      .clk_sys(clk_sys),
      .rst(rst),
      .go_act(go_act[b]),
      .go_rd(go_rd[b]),
      .go_wr(go_wr[b]),
      .go_ap(dc.ap),
      .go_pre(go_pre[b]),
      .burst_end(end_v[b]),
      .ap_delay(ap_delay),
      .force_idle(force_idle),
      .state(bst[b])
    );
    assign bank_state[b*8 +: 8] = bst[b];
  end

  // Handshake-style status outputs, derived combinationally.
  assign dev_state = dev_r;
  assign cmd_valid = live && dc.cmd != lbt_pkg::LBT_CMD_DESEL &&
                     dc.cmd != lbt_pkg::LBT_CMD_NOP && ok;
  assign cmd_illegal = live && !ok;
  assign burst_active = burst_r != '0;
  assign all_idle = &idle_v;
endmodule : lbt_tracker
`default_nettype wire

// file: core/lbt_pkg.sv
/*
  Package for the bank state tracker: command codes, bank states, timing
  figures and the decoded command carrier.
  Assumes a single 20 MHz system clock.
*/
`default_nettype none
package lbt_pkg;
  localparam int CLK_MHZ = 20;
  localparam int NBANK = 4;
  localparam int BA_W = 2;
  localparam int CNT_W = 8;
  localparam int CMD_W = 4;
  localparam int ADDR_AP_BIT = 10;
  localparam int ADDR_W = 13;

  // Figures in nanoseconds and clocks; cycles derived from the clock rate.
  localparam int T_RP_NS = 30;
  localparam int T_RCD_NS = 30;
  localparam int T_RFC_NS = 110;
  localparam int T_WR_NS = 15;
  localparam int T_MRD_CK = 2;
  localparam int T_WTR_CK = 1;
  localparam int BL_DEF = 4;
  localparam int CL_DEF = 3;
  localparam int RP_CYC = (T_RP_NS * CLK_MHZ + 999) / 1000;
  localparam int RCD_CYC = (T_RCD_NS * CLK_MHZ + 999) / 1000;
  localparam int RFC_CYC = (T_RFC_NS * CLK_MHZ + 999) / 1000;
  localparam int WR_CYC = (T_WR_NS * CLK_MHZ + 999) / 1000;

  // Pin code {ras_n, cas_n, we_n} with chip select low.
  localparam logic [2:0] PIN_NOP = 3'h7;
  localparam logic [2:0] PIN_ACT = 3'h3;
  localparam logic [2:0] PIN_RD = 3'h5;
  localparam logic [2:0] PIN_WR = 3'h4;
  localparam logic [2:0] PIN_PRE = 3'h2;
  localparam logic [2:0] PIN_REF = 3'h1;
  localparam logic [2:0] PIN_LMR = 3'h0;
  localparam logic [2:0] PIN_BST = 3'h6;

  typedef enum logic [CMD_W-1:0] {
    LBT_CMD_DESEL = 4'h0, LBT_CMD_NOP = 4'h1, LBT_CMD_ACT = 4'h2,
    LBT_CMD_RD = 4'h3, LBT_CMD_WR = 4'h4, LBT_CMD_PRE = 4'h5,
    LBT_CMD_REF = 4'h6, LBT_CMD_LMR = 4'h7, LBT_CMD_BST = 4'h8
  } lbt_cmd_t;

  typedef enum logic [7:0] {
    LBT_B_IDLE = 8'h01, LBT_B_ACTG = 8'h02, LBT_B_ACTV = 8'h04,
    LBT_B_RD = 8'h08, LBT_B_WR = 8'h10, LBT_B_PREG = 8'h20,
    LBT_B_RDAP = 8'h40, LBT_B_WRAP = 8'h80
  } lbt_bank_st_t;

  typedef enum logic [3:0] {
    LBT_D_NORM = 4'h1, LBT_D_REF = 4'h2, LBT_D_MRS = 4'h4, LBT_D_PALL = 4'h8
  } lbt_dev_st_t;

  typedef struct packed {
    lbt_cmd_t cmd;
    logic [BA_W-1:0] bank;
    logic ap;
  } lbt_dcmd_t;
endpackage : lbt_pkg
`default_nettype wire

// file: core/lbt_decode.sv
/*
  Command decoder: turns synchronised command pins into a decoded command.
  Assumes the pins were already brought into the clk_sys domain.
*/
`default_nettype none
module lbt_decode (
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [lbt_pkg::BA_W-1:0] ba,
  input wire logic a10,
  output lbt_pkg::lbt_dcmd_t dcmd
);
  always_comb begin
    dcmd.bank = ba;
    dcmd.ap = a10;
    if (cs_n) begin
      dcmd.cmd = lbt_pkg::LBT_CMD_DESEL;
    end else begin
      case ({ras_n, cas_n, we_n})
        lbt_pkg::PIN_NOP: dcmd.cmd = lbt_pkg::LBT_CMD_NOP;
        lbt_pkg::PIN_ACT: dcmd.cmd = lbt_pkg::LBT_CMD_ACT;
        lbt_pkg::PIN_RD: dcmd.cmd = lbt_pkg::LBT_CMD_RD;
        lbt_pkg::PIN_WR: dcmd.cmd = lbt_pkg::LBT_CMD_WR;
        lbt_pkg::PIN_PRE: dcmd.cmd = lbt_pkg::LBT_CMD_PRE;
        lbt_pkg::PIN_REF: dcmd.cmd = lbt_pkg::LBT_CMD_REF;
        lbt_pkg::PIN_LMR: dcmd.cmd = lbt_pkg::LBT_CMD_LMR;
        lbt_pkg::PIN_BST: dcmd.cmd = lbt_pkg::LBT_CMD_BST;
        default: dcmd.cmd = lbt_pkg::LBT_CMD_NOP;
      endcase
    end
  end
endmodule : lbt_decode
`default_nettype wire

// file: core/lbt_bank.sv
/*
  One bank's state machine with its own timer.
  Assumes the parent judges legality and passes only accepted commands.
*/
`default_nettype none
module lbt_bank #(
  parameter int RP = lbt_pkg::RP_CYC,
  parameter int RCD = lbt_pkg::RCD_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic go_act,
  input wire logic go_rd,
  input wire logic go_wr,
  input wire logic go_ap,
  input wire logic go_pre,
  input wire logic burst_end,
  input wire logic [lbt_pkg::CNT_W-1:0] ap_delay,
  input wire logic force_idle,
  output lbt_pkg::lbt_bank_st_t state
);
  lbt_pkg::lbt_bank_st_t st_r, st_nxt;
  logic [lbt_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
  localparam logic [lbt_pkg::CNT_W-1:0] RP_C = lbt_pkg::CNT_W'(RP);
  localparam logic [lbt_pkg::CNT_W-1:0] RCD_C = lbt_pkg::CNT_W'(RCD);
  wire logic expired = (cnt_r <= 1);

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = (cnt_r != '0) ? cnt_r - 1'b1 : cnt_r;
    if (force_idle) begin
      st_nxt = lbt_pkg::LBT_B_IDLE;
      cnt_nxt = '0;
    end else begin
      case (st_r)
        lbt_pkg::LBT_B_IDLE: if (go_act) begin
          st_nxt = lbt_pkg::LBT_B_ACTG;
          cnt_nxt = RCD_C;
        end
        lbt_pkg::LBT_B_ACTG: if (expired) begin
          st_nxt = lbt_pkg::LBT_B_ACTV;
        end
        lbt_pkg::LBT_B_ACTV, lbt_pkg::LBT_B_RD, lbt_pkg::LBT_B_WR: begin
          if (go_pre) begin
            st_nxt = lbt_pkg::LBT_B_PREG;
            cnt_nxt = RP_C;
          end else if ((go_rd || go_wr) && go_ap) begin
            st_nxt = go_rd ? lbt_pkg::LBT_B_RDAP : lbt_pkg::LBT_B_WRAP;
            cnt_nxt = ap_delay + RP_C;
          end else if (go_rd) begin
            st_nxt = lbt_pkg::LBT_B_RD;
          end else if (go_wr) begin
            st_nxt = lbt_pkg::LBT_B_WR;
          end else if (burst_end && st_r != lbt_pkg::LBT_B_ACTV) begin
            st_nxt = lbt_pkg::LBT_B_ACTV;
          end
        end
        lbt_pkg::LBT_B_PREG, lbt_pkg::LBT_B_RDAP, lbt_pkg::LBT_B_WRAP:
          if (expired) begin
            st_nxt = lbt_pkg::LBT_B_IDLE;
          end
        default: begin
          st_nxt = lbt_pkg::LBT_B_IDLE;
          cnt_nxt = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_r <= lbt_pkg::LBT_B_IDLE;
      cnt_r <= '0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign state = st_r;
endmodule : lbt_bank
`default_nettype wire

// file: bench/lbt_tracker_properties.sv
/*
  Checker for the bank state tracker: timing and legality of its outputs.
  Assumes default counts: RP 1, RCD 1, RFC 3, MRD 2, BL 4.
*/
`default_nettype none
module lbt_props (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic cke,
  input wire logic tracking_en,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [lbt_pkg::BA_W-1:0] ba,
  input wire logic [lbt_pkg::ADDR_W-1:0] addr,
  input wire logic [lbt_pkg::NBANK*8-1:0] bank_state,
  input wire logic [3:0] dev_state,
  input wire logic cmd_valid,
  input wire logic cmd_illegal,
  input wire logic burst_active,
  input wire logic all_idle
);
  logic [8:0] p1_r;
  logic [8:0] p2_r;
  logic cke3_r;
  logic [2:0] code;
  logic judged;
  logic exe;
  logic to_bank;
  logic rd_any;

  // Mirror of the pin synchroniser, so each pulse is tied to its own pins.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      p1_r <= 9'h1ff;
      p2_r <= 9'h1ff;
      cke3_r <= 1'b0;
    end else begin
      p1_r <= {cke, tracking_en, cs_n, ras_n, cas_n, we_n, ba,
        addr[lbt_pkg::ADDR_AP_BIT]};
      p2_r <= p1_r;
      cke3_r <= p2_r[8];
    end
  end

  assign code = p2_r[5:3];
  assign judged = p2_r[8] && cke3_r && p2_r[7] && !p2_r[6];
  assign exe = judged && code != lbt_pkg::PIN_NOP &&
    code != lbt_pkg::PIN_BST;
  assign to_bank = exe && code[2] != code[1] &&
    !(code == lbt_pkg::PIN_PRE && p2_r[0]);

  always_comb begin
    rd_any = 1'b0;
    for (int i = 0; i < 4; i++) begin
      rd_any = rd_any || bank_state[8*i +: 8] == 8'h08;
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence ref_run;
    (dev_state == 4'h2) [*3] ##1 dev_state == 4'h1 && all_idle;
  endsequence
  sequence mrs_run;
    (dev_state == 4'h4) [*2] ##1 dev_state == 4'h1 && all_idle;
  endsequence

  pulse_excl_a:
    assert property (!(cmd_valid && cmd_illegal)) else $error("both pulses");
  gate_quiet_a:
    assert property (!judged |-> !cmd_valid && !cmd_illegal)
      else $error("unjudged command pulsed");
  dev_busy_a:
    assert property (exe && dev_state != 4'h1 |-> cmd_illegal)
      else $error("command taken in device-wide state");
  ref_time_a:
    assert property ($rose(dev_state == 4'h2) |-> ref_run)
      else $error("refresh length wrong");
  mrs_time_a:
    assert property ($rose(dev_state == 4'h4) |-> mrs_run)
      else $error("mode access length wrong");
  pall_time_a:
    assert property (cmd_valid && code == lbt_pkg::PIN_PRE && p2_r[0] |=>
      dev_state == 4'h8 ##1 dev_state == 4'h1 && all_idle)
      else $error("precharge all wrong");
  need_idle_a:
    assert property (exe && !all_idle && (code == lbt_pkg::PIN_REF ||
      code == lbt_pkg::PIN_LMR) |-> cmd_illegal)
      else $error("refresh taken with open bank");
  bst_cut_a:
    assert property (cmd_valid && judged && code == lbt_pkg::PIN_BST &&
      rd_any |=> !rd_any && !burst_active) else $error("read not cut");

  for (genvar b = 0; b < 4; b++) begin : g_bank
    logic [7:0] st;
    logic hit;
    assign st = bank_state[8*b +: 8];
    assign hit = cmd_valid && judged && p2_r[2:1] == 2'(b);
    sequence rd_quiet;
      hit && code == lbt_pkg::PIN_RD && !p2_r[0] ##1 !cmd_valid [*2];
    endsequence
    act_time_a:
      assert property (hit && code == lbt_pkg::PIN_ACT |=>
        st == 8'h02 ##1 st == 8'h04) else $error("activate timing");
    pre_time_a:
      assert property (hit && code == lbt_pkg::PIN_PRE && !p2_r[0] |=>
        st == 8'h20 ##1 st == 8'h01) else $error("precharge timing");
    rd_run_a:
      assert property (rd_quiet |=> st == 8'h04 && $past(st, 2) == 8'h08)
        else $error("read burst length");
    rdap_time_a:
      assert property (hit && code == lbt_pkg::PIN_RD && p2_r[0] |=>
        (st == 8'h40) [*3] ##1 st == 8'h01) else $error("auto precharge");
    busy_bank_a:
      assert property (to_bank && p2_r[2:1] == 2'(b) && dev_state == 4'h1
        && st inside {8'h02, 8'h20, 8'h40, 8'h80} |-> cmd_illegal)
        else $error("busy bank took a command");
  end
endmodule : lbt_props

bind lbt_tracker lbt_props u_lbt_props (.clk_sys(clk_sys), .rst(rst),
  .cke(cke), .tracking_en(tracking_en), .cs_n(cs_n), .ras_n(ras_n),
  .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr),
  .bank_state(bank_state), .dev_state(dev_state), .cmd_valid(cmd_valid),
  .cmd_illegal(cmd_illegal), .burst_active(burst_active),
  .all_idle(all_idle));
`default_nettype wire

// file: bench/lbt_ctl_model.sv
/*
  Memory controller model: issues one command per call on the pins.
  Assumes the tracker samples its pins on the rising edge of clk_sys.
*/
`default_nettype none
module lbt_ctl_model (
  input wire logic clk_sys,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [lbt_pkg::BA_W-1:0] ba,
  output logic [lbt_pkg::ADDR_W-1:0] addr
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    cs_n = 1'b1;
    {ras_n, cas_n, we_n} = 3'h7;
    ba = 2'h0;
    addr = 13'h0000;
  end

  // One command for one edge, then gap deselected edges. Released lines
  // show the inverse of the command, but addr flips on each edge and so repeats the command's on every second one.
  task automatic send(input logic [2:0] code, input logic [1:0] b,
      input logic ap, input int gap);
    @(posedge clk_sys);
    cs_n <= 1'b0;
    {ras_n, cas_n, we_n} <= code;
    ba <= b;
    addr <= 13'(ap) << lbt_pkg::ADDR_AP_BIT;
    for (int i = 0; i < gap; i++) begin
      @(posedge clk_sys);
      cs_n <= 1'b1;
      {ras_n, cas_n, we_n} <= ~code;
      ba <= ~b;
      addr <= ~addr;
    end
  endtask : send
endmodule : lbt_ctl_model
`default_nettype wire

// file: bench/lbt_tracker_test.sv
/*
  Self-checking bench for the bank state tracker: each task issues commands
  through the controller model and judges pulses and bank states.
  Assumes the tracker's default counts and a 20 MHz clock.
*/
`default_nettype none
module lbt_tracker_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [2:0] c_act = lbt_pkg::PIN_ACT;
  localparam logic [2:0] c_rd = lbt_pkg::PIN_RD;
  localparam logic [2:0] c_wr = lbt_pkg::PIN_WR;
  localparam logic [2:0] c_pre = lbt_pkg::PIN_PRE;
  logic clk_sys, rst, cke, tracking_en, cs_n, ras_n, cas_n, we_n;
  logic [1:0] ba;
  logic [12:0] addr;
  logic [31:0] bank_state;
  logic [3:0] dev_state;
  logic cmd_valid, cmd_illegal, burst_active, all_idle;
  int err_total, total_checks;
  logic res_q[$];

  lbt_tracker u_lbt_tracker (.clk_sys(clk_sys), .rst(rst), .cke(cke),
    .tracking_en(tracking_en), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .ba(ba), .addr(addr), .bank_state(bank_state),
    .dev_state(dev_state), .cmd_valid(cmd_valid),
    .cmd_illegal(cmd_illegal), .burst_active(burst_active),
    .all_idle(all_idle));
  lbt_ctl_model u_lbt_ctl_model (.clk_sys(clk_sys), .cs_n(cs_n),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr));

  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (cmd_valid === 1'b1 || cmd_illegal === 1'b1) begin
      res_q.push_back(cmd_valid);
    end
  end

  task automatic cmd(input logic [2:0] k, input logic [1:0] b,
      input logic ap, input int gap);
    u_lbt_ctl_model.send(k, b, ap, gap);
  endtask : cmd

  task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      err_total++;
    end
  endtask : chk

  // Accepted pulses read 1, refused 0, oldest in the highest bit.
  task automatic pulses(input int n, input logic [7:0] exp);
    logic [7:0] got = 8'h00;
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
    foreach (res_q[i]) got = {got[6:0], res_q[i]};
    chk("pulse count", n, res_q.size());
    chk("pulse kinds", exp, got);
    res_q.delete();
  endtask : pulses

  task automatic t_act;
    chk("banks", 32'h0101_0101, bank_state);
    cmd(c_act, 2'h1, 1'b0, 4);
    cmd(c_act, 2'h2, 1'b0, 0);
    cmd(c_act, 2'h2, 1'b0, 4);
    cmd(c_act, 2'h1, 1'b0, 4);
    pulses(4, 8'h0c);
    chk("bank 1", 8'h04, bank_state[15:8]);
    cmd(c_pre, 2'h2, 1'b0, 4);
    cmd(lbt_pkg::PIN_RD, 2'h1, 1'b0, 0);
    cmd(lbt_pkg::PIN_BST, 2'h3, 1'b0, 4);
    pulses(3, 8'h07);
    chk("bank 2", 8'h01, bank_state[23:16]);
    chk("bank 1", 8'h04, bank_state[15:8]);
  endtask : t_act

  task automatic t_rdap;
    cmd(c_act, 2'h0, 1'b0, 4);
    cmd(c_rd, 2'h1, 1'b1, 0);
    cmd(c_rd, 2'h0, 1'b0, 5);
    pulses(3, 8'h06);
    chk("bank 1", 8'h01, bank_state[15:8]);
    cmd(c_act, 2'h1, 1'b0, 4);
    cmd(c_rd, 2'h1, 1'b1, 1);
    cmd(c_rd, 2'h0, 1'b0, 5);
    pulses(3, 8'h07);
  endtask : t_rdap

  task automatic t_wrap;
    cmd(c_act, 2'h1, 1'b0, 4);
    cmd(c_wr, 2'h1, 1'b1, 0);
    cmd(c_act, 2'h2, 1'b0, 2);
    cmd(c_rd, 2'h0, 1'b0, 6);
    cmd(c_act, 2'h1, 1'b0, 4);
    cmd(c_wr, 2'h1, 1'b1, 0);
    cmd(c_act, 2'h3, 1'b0, 1);
    cmd(c_rd, 2'h0, 1'b0, 6);
    pulses(8, 8'hfe);
    chk("bank 1", 8'h01, bank_state[15:8]);
  endtask : t_wrap

  task automatic t_dev;
    cmd(lbt_pkg::PIN_REF, 2'h0, 1'b0, 4);
    cmd(c_pre, 2'h0, 1'b1, 0);
    cmd(c_act, 2'h0, 1'b0, 6);
    pulses(3, 8'h02);
    chk("all idle", 1'b1, all_idle);
    for (int i = 0; i < 2; i++) begin
      cmd(i ? lbt_pkg::PIN_LMR : lbt_pkg::PIN_REF, 2'h0, 1'b0, 0);
      cmd(c_act, 2'h1, 1'b0, 6);
      pulses(2, 8'h02);
      chk("device", 4'h1, dev_state);
      chk("banks", 32'h0101_0101, bank_state);
    end
  endtask : t_dev

  task automatic t_gate;
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_sys);
      cke <= i[0];
      tracking_en <= !i[0];
      cmd(c_act, 2'h3, 1'b0, 6);
      pulses(0, 8'h00);
      chk("bank 3", 8'h01, bank_state[31:24]);
      @(posedge clk_sys);
      cke <= 1'b1;
      tracking_en <= 1'b1;
      repeat (4) @(posedge clk_sys);
    end
  endtask : t_gate

  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test

  initial begin
    clk_sys = 1'b0;
    rst = 1'b1;
    cke = 1'b1;
    tracking_en = 1'b1;
    err_total = 0;
    total_checks = 0;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    t_act();
    t_rdap();
    t_wrap();
    t_dev();
    t_gate();
    finish_test();
  end

  // The whole sequence needs a few hundred cycles; this allows far more.
  initial begin
    repeat (3000) @(posedge clk_sys);
    err_total++;
    finish_test();
  end
endmodule : lbt_tracker_test
`default_nettype wire
